// >>> mpsgc_asserts.sv
// port timing assertions for the port statistics block
module mpsgc_asserts (
    input wire logic                        i_ref_clk,
    input wire logic                        i_reset,
    input wire logic                        i_reg_rd,
    input wire logic                        o_reg_rvalid,
    input wire logic                        i_phy_rx_dv,
    input wire logic                        i_mac_tx_en,
    input wire logic                        o_rx_dv,
    input wire logic                        o_mac_loopback_enable,
    input wire logic                        i_rx_frame_end,
    input wire mpsgc_pkg::mpsgc_rx_status_s i_rx_status,
    input wire logic                        o_rx_frame_accept,
    input wire logic                        o_rx_frame_drop,
    input wire logic                        o_rx_gap_error_flag,
    input wire logic                        i_tx_frame_end,
    input wire logic                        o_tx_gap_busy
);
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (i_reset);
    property p_rvalid; 1'b1 |=> o_reg_rvalid == $past(i_reg_rd); endproperty
    a_rvalid: assert property (p_rvalid) else $error("read answer mistimed");
    property p_answer; 1'b1 |=> (o_rx_frame_accept || o_rx_frame_drop) == $past(i_rx_frame_end);
    endproperty
    a_answer: assert property (p_answer) else $error("frame answer mistimed");
    property p_phy; i_rx_frame_end && i_rx_status.phy_err |=> o_rx_frame_drop; endproperty
    a_phy: assert property (p_phy) else $error("phy error frame kept");
    property p_align; i_rx_frame_end && i_rx_status.align_err |=> o_rx_frame_drop; endproperty
    a_align: assert property (p_align) else $error("align error frame kept");
    property p_full; i_rx_frame_end && i_rx_status.fifo_full |=> o_rx_frame_drop; endproperty
    a_full: assert property (p_full) else $error("full fifo frame kept");
    property p_filt; i_rx_frame_end && i_rx_status.filter_reject |=> o_rx_frame_drop; endproperty
    a_filt: assert property (p_filt) else $error("filtered frame kept");
    property p_gap_drop; o_rx_gap_error_flag |-> o_rx_frame_drop && !o_rx_frame_accept; endproperty
    a_gap_drop: assert property (p_gap_drop) else $error("gap error frame kept");
    property p_busy_go; i_tx_frame_end && !o_tx_gap_busy |=> o_tx_gap_busy; endproperty
    a_busy_go: assert property (p_busy_go) else $error("gap not started");
    property p_busy_min; $rose(o_tx_gap_busy) |-> $past(i_tx_frame_end) ##0 o_tx_gap_busy[*8];
    endproperty
    a_busy_min: assert property (p_busy_min) else $error("gap start or length wrong");
    property p_loop_on; o_mac_loopback_enable |=> o_rx_dv == $past(i_mac_tx_en); endproperty
    a_loop_on: assert property (p_loop_on) else $error("loopback path wrong");
    property p_loop_off; !o_mac_loopback_enable |=> o_rx_dv == $past(i_phy_rx_dv); endproperty
    a_loop_off: assert property (p_loop_off) else $error("normal path wrong");
endmodule : mpsgc_asserts

// >>> mpsgc_counter.sv
// wrapping 32-bit event counter
module mpsgc_counter (
    input  wire logic        i_ref_clk,
    input  wire logic        i_reset,
    input  wire logic        i_inc,
    output logic [31:0]      o_count
);

    logic [31:0] next_count;

    assign next_count = i_inc ? o_count + 32'h1 : o_count;

    always_ff @(posedge i_ref_clk or posedge i_reset) begin
        if (i_reset) begin
            o_count <= mpsgc_pkg::RST_COUNTER;
        end else begin
            o_count <= next_count;
        end
    end

endmodule : mpsgc_counter

// >>> mpsgc_phy_model.sv
// receive side of the PHY driving carrier and nibbles on the MII
module mpsgc_phy_model (
    input  wire logic  i_ref_clk,
    output logic       o_rx_dv,
    output logic [3:0] o_rxd
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        o_rx_dv = 1'b0;
        o_rxd = 4'h0;
    end
    // nibble changes every cycle, so no stale value survives idle
    always @(negedge i_ref_clk) begin
        o_rxd <= o_rx_dv ? o_rxd + 4'h1 : ~o_rxd;
    end
    task automatic send(input int n);
        @(negedge i_ref_clk);
        o_rx_dv <= 1'b1;
        repeat (n) @(negedge i_ref_clk);
        o_rx_dv <= 1'b0;
    endtask : send
endmodule : mpsgc_phy_model

// >>> mpsgc_pkg.sv
// shared constants and types for the port statistics and gap control block
package mpsgc_pkg;

    // register offsets, used directly as register addresses
    localparam logic [7:0]  OFS_RX_ALIGN_ERR   = 8'ha5;
    localparam logic [7:0]  OFS_RX_LEN_ERR     = 8'ha6;
    localparam logic [7:0]  OFS_RX_PHY_ERR     = 8'ha7;
    localparam logic [7:0]  OFS_TX_FRAME       = 8'ha8;
    localparam logic [7:0]  OFS_TX_BCAST       = 8'ha9;
    localparam logic [7:0]  OFS_TX_MCAST       = 8'haa;
    localparam logic [7:0]  OFS_TX_UCAST       = 8'hab;
    localparam logic [7:0]  OFS_RX_DROP_FULL   = 8'hac;
    localparam logic [7:0]  OFS_RX_DROP_FILT   = 8'had;
    localparam logic [7:0]  OFS_RX_GAP_ERR     = 8'hae;
    localparam logic [7:0]  OFS_TX_GAP         = 8'hb0;
    localparam logic [7:0]  OFS_LOOPBACK       = 8'hb3;
    localparam logic [7:0]  OFS_RX_CRC_EN      = 8'hb4;
    localparam logic [7:0]  OFS_RX_GAP_MIN     = 8'hb5;
    localparam logic [7:0]  OFS_RX_MAX_LEN     = 8'hb6;
    localparam logic [7:0]  OFS_RX_MIN_LEN     = 8'hb7;

    // counter slots, in offset order from the first counter
    localparam int          NUM_COUNTERS       = 10;
    localparam int          CNT_ALIGN          = 0;
    localparam int          CNT_LENGTH         = 1;
    localparam int          CNT_PHY            = 2;
    localparam int          CNT_TX_FRAME       = 3;
    localparam int          CNT_TX_BCAST       = 4;
    localparam int          CNT_TX_MCAST       = 5;
    localparam int          CNT_TX_UCAST       = 6;
    localparam int          CNT_DROP_FULL      = 7;
    localparam int          CNT_DROP_FILT      = 8;
    localparam int          CNT_GAP            = 9;

    // field widths and positions
    localparam int          TX_GAP_W           = 8;
    localparam int          RX_GAP_W           = 6;
    localparam int          LEN_W              = 16;
    localparam int          LOOPBACK_BIT       = 0;
    localparam int          CRC_EN_BIT         = 0;
    localparam int          BITS_PER_GAP_UNIT  = 8;

    // reset values
    localparam logic [31:0] RST_COUNTER        = 32'h0000_0000;
    localparam logic [7:0]  RST_TX_GAP         = 8'h0b;
    localparam logic        RST_LOOPBACK       = 1'h0;
    localparam logic        RST_CRC_EN         = 1'h1;
    localparam logic [5:0]  RST_RX_GAP_MIN     = 6'h0a;
    localparam logic [15:0] RST_RX_MAX_LEN     = 16'h0618;
    localparam logic [15:0] RST_RX_MIN_LEN     = 16'h0040;

    // timing: one bit time at 10 Mbps against a 200 MHz clock
    localparam int          CLK_PERIOD_PS      = 5000;
    localparam int          BIT_TIME_NS        = 100;
    localparam int          BIT_TIME_CYCLES    =
        (BIT_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int          BIT_DIV_W          = 5;
    localparam int          GAP_CNT_W          = 12;

    typedef struct packed {
        logic [15:0] length;
        logic        crc_bad;
        logic        align_err;
        logic        phy_err;
        logic        fifo_full;
        logic        filter_reject;
    } mpsgc_rx_status_s;

    typedef struct packed {
        logic        broadcast;
        logic        multicast;
    } mpsgc_tx_class_s;

    typedef enum logic [0:0] {
        TX_IDLE = 1'b0,
        TX_GAP  = 1'b1
    } mpsgc_tx_state_e;

endpackage : mpsgc_pkg

// >>> mpsgc_port_stats.sv
// port statistics counters and frame gap control
module mpsgc_port_stats (
    input  wire logic                        i_ref_clk,
    input  wire logic                        i_reset,
    // register port
    input  wire logic                        i_reg_wr,
    input  wire logic                        i_reg_rd,
    input  wire logic [7:0]                  i_reg_addr,
    input  wire logic [31:0]                 i_reg_wdata,
    output logic [31:0]                      o_reg_rdata,
    output logic                             o_reg_rvalid,
    // MII from the PHY and from the transmitter
    input  wire logic                        i_phy_rx_dv,
    input  wire logic [3:0]                  i_phy_rxd,
    input  wire logic                        i_mac_tx_en,
    input  wire logic [3:0]                  i_mac_txd,
    output logic                             o_rx_dv,
    output logic [3:0]                       o_rxd,
    output logic                             o_mac_loopback_enable,
    // receive frame completion
    input  wire logic                        i_rx_frame_end,
    input  wire mpsgc_pkg::mpsgc_rx_status_s i_rx_status,
    output logic                             o_rx_frame_accept,
    output logic                             o_rx_frame_drop,
    output logic                             o_rx_gap_error_flag,
    output logic                             o_rx_crc_check_enable,
    // transmit frame completion and gap
    input  wire logic                        i_tx_frame_end,
    input  wire mpsgc_pkg::mpsgc_tx_class_s  i_tx_class,
    output logic                             o_tx_gap_busy
);

    // configuration registers
    logic [mpsgc_pkg::TX_GAP_W-1:0]  tx_gap_setting;
    logic                            mac_loopback_enable;
    logic                            rx_crc_check_enable;
    logic [mpsgc_pkg::RX_GAP_W-1:0]  rx_gap_minimum;
    logic [mpsgc_pkg::LEN_W-1:0]     rx_max_frame_length;
    logic [mpsgc_pkg::LEN_W-1:0]     rx_min_frame_length;

    logic [31:0]                     counts [mpsgc_pkg::NUM_COUNTERS];
    logic [mpsgc_pkg::NUM_COUNTERS-1:0] inc;

    // bit time divider
    logic [mpsgc_pkg::BIT_DIV_W-1:0] bit_div;
    logic [mpsgc_pkg::BIT_DIV_W-1:0] next_bit_div;
    logic                            bit_tick;

    // receive gap measurement
    logic                            rx_dv_eff;
    logic [3:0]                      rxd_eff;
    logic                            rx_dv_prev;
    logic                            rx_start;
    logic [mpsgc_pkg::GAP_CNT_W-1:0] rx_gap_bits;
    logic [mpsgc_pkg::GAP_CNT_W-1:0] next_rx_gap_bits;
    logic [mpsgc_pkg::GAP_CNT_W-1:0] rx_gap_limit;
    logic                            rx_gap_short;
    logic                            frame_gap_bad;
    logic                            next_frame_gap_bad;

    // receive frame decision
    logic                            len_bad;
    logic                            crc_drop;
    logic                            rx_error;
    logic                            drop_full;
    logic                            drop_filt;
    logic                            accept;

    // transmit gap
    mpsgc_pkg::mpsgc_tx_state_e      tx_state;
    mpsgc_pkg::mpsgc_tx_state_e      next_tx_state;
    logic [mpsgc_pkg::GAP_CNT_W-1:0] tx_gap_left;
    logic [mpsgc_pkg::GAP_CNT_W-1:0] next_tx_gap_left;
    logic [mpsgc_pkg::GAP_CNT_W-1:0] tx_gap_load;

    // register decode
    logic                            wr_tx_gap;
    logic                            wr_loop;
    logic                            wr_crc;
    logic                            wr_rx_gap;
    logic                            wr_max;
    logic                            wr_min;
    logic                            rd_is_counter;
    logic [7:0]                      rd_slot;
    logic [31:0]                     rd_value;

    // ---------------------------------------------------------------
    // bit time divider, free running
    // gaps count whole ticks, so a gap may end up to a tick early
    assign bit_tick     = (bit_div == mpsgc_pkg::BIT_DIV_W'(mpsgc_pkg::BIT_TIME_CYCLES - 1));
    assign next_bit_div = bit_tick ? '0 : bit_div + mpsgc_pkg::BIT_DIV_W'(1);

    always_ff @(posedge i_ref_clk or posedge i_reset) begin
        if (i_reset) begin
            bit_div <= '0;
        end else begin
            bit_div <= next_bit_div;
        end
    end

    // ---------------------------------------------------------------
    // loop transmit into receive
    assign rx_dv_eff = mac_loopback_enable ? i_mac_tx_en : i_phy_rx_dv;
    assign rxd_eff   = mac_loopback_enable ? i_mac_txd : i_phy_rxd;

    always_ff @(posedge i_ref_clk or posedge i_reset) begin
        if (i_reset) begin
            o_rx_dv <= 1'b0;
            o_rxd   <= 4'h0;
        end else begin
            o_rx_dv <= rx_dv_eff;
            o_rxd   <= rxd_eff;
        end
    end

    assign o_mac_loopback_enable = mac_loopback_enable;
    assign o_rx_crc_check_enable = rx_crc_check_enable;

    // ---------------------------------------------------------------
    // idle bit times since the last carrier, saturating
    assign rx_start         = rx_dv_eff & ~rx_dv_prev;
    assign next_rx_gap_bits = rx_dv_eff ? '0 :
                              (bit_tick && (rx_gap_bits != '1)) ?
                              rx_gap_bits + mpsgc_pkg::GAP_CNT_W'(1) : rx_gap_bits;

    // gap must exceed setting times eight
    assign rx_gap_limit = mpsgc_pkg::GAP_CNT_W'(rx_gap_minimum)
                          * mpsgc_pkg::GAP_CNT_W'(mpsgc_pkg::BITS_PER_GAP_UNIT);
    assign rx_gap_short = rx_start && (rx_gap_bits <= rx_gap_limit);

    // a new start overrides the end-of-frame clear
    assign next_frame_gap_bad = rx_start ? rx_gap_short :
                                (i_rx_frame_end ? 1'b0 : frame_gap_bad);

    always_ff @(posedge i_ref_clk or posedge i_reset) begin
        if (i_reset) begin
            rx_dv_prev    <= 1'b0;
            // saturated, so the first frame after reset is never gap-bad
            rx_gap_bits   <= '1;
            frame_gap_bad <= 1'b0;
        end else begin
            rx_dv_prev    <= rx_dv_eff;
            rx_gap_bits   <= next_rx_gap_bits;
            frame_gap_bad <= next_frame_gap_bad;
        end
    end

    // ---------------------------------------------------------------
    // both length bounds accept equality
    // lower and upper length bounds
    assign len_bad  = (i_rx_status.length < rx_min_frame_length)
                   || (i_rx_status.length > rx_max_frame_length);
    // bad CRC only drops when checking
    assign crc_drop = i_rx_status.crc_bad & rx_crc_check_enable;
    assign rx_error = frame_gap_bad | i_rx_status.phy_err | i_rx_status.align_err
                    | len_bad | crc_drop;
    assign drop_full = ~rx_error & i_rx_status.fifo_full;
    assign drop_filt = ~rx_error & ~i_rx_status.fifo_full & i_rx_status.filter_reject;
    assign accept    = ~rx_error & ~i_rx_status.fifo_full & ~i_rx_status.filter_reject;
    // drop is the complement of accept at each frame end

    always_ff @(posedge i_ref_clk or posedge i_reset) begin
        if (i_reset) begin
            o_rx_frame_accept   <= 1'b0;
            o_rx_frame_drop     <= 1'b0;
            o_rx_gap_error_flag <= 1'b0;
        end else begin
            o_rx_frame_accept   <= i_rx_frame_end & accept;
            o_rx_frame_drop     <= i_rx_frame_end & ~accept;
            o_rx_gap_error_flag <= i_rx_frame_end & frame_gap_bad;
        end
    end

    // ---------------------------------------------------------------
    // counter increments, one per frame end
    // alignment errors
    assign inc[mpsgc_pkg::CNT_ALIGN]     = i_rx_frame_end & i_rx_status.align_err;
    assign inc[mpsgc_pkg::CNT_LENGTH]    = i_rx_frame_end & len_bad;
    assign inc[mpsgc_pkg::CNT_PHY]       = i_rx_frame_end & i_rx_status.phy_err;
    assign inc[mpsgc_pkg::CNT_TX_FRAME]  = i_tx_frame_end;
    assign inc[mpsgc_pkg::CNT_TX_BCAST]  = i_tx_frame_end & i_tx_class.broadcast;
    assign inc[mpsgc_pkg::CNT_TX_MCAST]  = i_tx_frame_end & ~i_tx_class.broadcast
                                         & i_tx_class.multicast;
    assign inc[mpsgc_pkg::CNT_TX_UCAST]  = i_tx_frame_end & ~i_tx_class.broadcast
                                         & ~i_tx_class.multicast;
    assign inc[mpsgc_pkg::CNT_DROP_FULL] = i_rx_frame_end & drop_full;
    assign inc[mpsgc_pkg::CNT_DROP_FILT] = i_rx_frame_end & drop_filt;
    assign inc[mpsgc_pkg::CNT_GAP]       = i_rx_frame_end & frame_gap_bad;

    for (genvar g = 0; g < mpsgc_pkg::NUM_COUNTERS; g++) begin : g_cnt
        mpsgc_counter u_counter (
            .i_ref_clk (i_ref_clk),
            .i_reset   (i_reset),
            .i_inc     (inc[g]),
            .o_count   (counts[g])
        );
    end

    // ---------------------------------------------------------------
    // gap length counts ticks of the free-running divider
    // transmit gap in bit times
    assign tx_gap_load = (mpsgc_pkg::GAP_CNT_W'(tx_gap_setting) + mpsgc_pkg::GAP_CNT_W'(1))
                         * mpsgc_pkg::GAP_CNT_W'(mpsgc_pkg::BITS_PER_GAP_UNIT);

    always_comb begin
        next_tx_state    = tx_state;
        next_tx_gap_left = tx_gap_left;
        unique case (tx_state)
            mpsgc_pkg::TX_IDLE: begin
                if (i_tx_frame_end) begin
                    next_tx_state    = mpsgc_pkg::TX_GAP;
                    next_tx_gap_left = tx_gap_load;
                end
            end
            // a frame end here counts but does not restart the gap
            mpsgc_pkg::TX_GAP: begin
                if (bit_tick) begin
                    next_tx_gap_left = tx_gap_left - mpsgc_pkg::GAP_CNT_W'(1);
                    if (tx_gap_left == mpsgc_pkg::GAP_CNT_W'(1)) begin
                        next_tx_state = mpsgc_pkg::TX_IDLE;
                    end
                end
            end
        endcase
    end

    always_ff @(posedge i_ref_clk or posedge i_reset) begin
        if (i_reset) begin
            tx_state    <= mpsgc_pkg::TX_IDLE;
            tx_gap_left <= '0;
        end else begin
            tx_state    <= next_tx_state;
            tx_gap_left <= next_tx_gap_left;
        end
    end

    // transmitter must not start a frame while this is high
    assign o_tx_gap_busy = (tx_state == mpsgc_pkg::TX_GAP);

    // ---------------------------------------------------------------
    // register writes
    // counter offsets are not decoded here, so they ignore writes
    assign wr_tx_gap = i_reg_wr && (i_reg_addr == mpsgc_pkg::OFS_TX_GAP);
    assign wr_loop   = i_reg_wr && (i_reg_addr == mpsgc_pkg::OFS_LOOPBACK);
    assign wr_crc    = i_reg_wr && (i_reg_addr == mpsgc_pkg::OFS_RX_CRC_EN);
    assign wr_rx_gap = i_reg_wr && (i_reg_addr == mpsgc_pkg::OFS_RX_GAP_MIN);
    assign wr_max    = i_reg_wr && (i_reg_addr == mpsgc_pkg::OFS_RX_MAX_LEN);
    assign wr_min    = i_reg_wr && (i_reg_addr == mpsgc_pkg::OFS_RX_MIN_LEN);

    always_ff @(posedge i_ref_clk or posedge i_reset) begin
        if (i_reset) begin
            tx_gap_setting      <= mpsgc_pkg::RST_TX_GAP;
            mac_loopback_enable <= mpsgc_pkg::RST_LOOPBACK;
            rx_crc_check_enable <= mpsgc_pkg::RST_CRC_EN;
            rx_gap_minimum      <= mpsgc_pkg::RST_RX_GAP_MIN;
            rx_max_frame_length <= mpsgc_pkg::RST_RX_MAX_LEN;
            rx_min_frame_length <= mpsgc_pkg::RST_RX_MIN_LEN;
        end else begin
            if (wr_tx_gap) begin
                tx_gap_setting <= i_reg_wdata[mpsgc_pkg::TX_GAP_W-1:0];
            end
            if (wr_loop) begin
                mac_loopback_enable <= i_reg_wdata[mpsgc_pkg::LOOPBACK_BIT];
            end
            if (wr_crc) begin
                rx_crc_check_enable <= i_reg_wdata[mpsgc_pkg::CRC_EN_BIT];
            end
            if (wr_rx_gap) begin
                rx_gap_minimum <= i_reg_wdata[mpsgc_pkg::RX_GAP_W-1:0];
            end
            if (wr_max) begin
                rx_max_frame_length <= i_reg_wdata[mpsgc_pkg::LEN_W-1:0];
            end
            if (wr_min) begin
                rx_min_frame_length <= i_reg_wdata[mpsgc_pkg::LEN_W-1:0];
            end
        end
    end

    // ---------------------------------------------------------------
    // register reads, one cycle latency
    assign rd_is_counter = (i_reg_addr >= mpsgc_pkg::OFS_RX_ALIGN_ERR)
                        && (i_reg_addr <= mpsgc_pkg::OFS_RX_GAP_ERR);
    assign rd_slot       = i_reg_addr - mpsgc_pkg::OFS_RX_ALIGN_ERR;

    // the range check keeps the counter index inside the array
    // reserved bits and unmapped read zero
    assign rd_value =
        rd_is_counter ? counts[rd_slot[3:0]] :
        (i_reg_addr == mpsgc_pkg::OFS_TX_GAP)     ? {24'h0, tx_gap_setting} :
        (i_reg_addr == mpsgc_pkg::OFS_LOOPBACK)   ? {31'h0, mac_loopback_enable} :
        (i_reg_addr == mpsgc_pkg::OFS_RX_CRC_EN)  ? {31'h0, rx_crc_check_enable} :
        (i_reg_addr == mpsgc_pkg::OFS_RX_GAP_MIN) ? {26'h0, rx_gap_minimum} :
        (i_reg_addr == mpsgc_pkg::OFS_RX_MAX_LEN) ? {16'h0, rx_max_frame_length} :
        (i_reg_addr == mpsgc_pkg::OFS_RX_MIN_LEN) ? {16'h0, rx_min_frame_length} :
        32'h0;

    always_ff @(posedge i_ref_clk or posedge i_reset) begin
        if (i_reset) begin
            o_reg_rdata  <= 32'h0;
            o_reg_rvalid <= 1'b0;
        end else begin
            o_reg_rvalid <= i_reg_rd;
            if (i_reg_rd) begin
                o_reg_rdata <= rd_value;
            end
        end
    end

endmodule : mpsgc_port_stats

// >>> mpsgc_port_stats_test.sv
// self-checking bench for the port statistics block
module mpsgc_port_stats_test;
    timeunit 1ns;
    timeprecision 1ps;
    logic        i_ref_clk = 1'b0, i_reset = 1'b1, i_reg_wr = 1'b0, i_reg_rd = 1'b0;
    logic [7:0]  i_reg_addr = 8'h00;
    logic [31:0] i_reg_wdata = 32'h0, o_reg_rdata;
    logic        o_reg_rvalid, i_phy_rx_dv, i_mac_tx_en = 1'b0, o_rx_dv, o_mac_loopback_enable;
    logic [3:0]  i_phy_rxd, i_mac_txd = 4'h0, o_rxd;
    logic        i_rx_frame_end = 1'b0, o_rx_frame_accept, o_rx_frame_drop, o_rx_gap_error_flag;
    logic        o_rx_crc_check_enable, i_tx_frame_end = 1'b0, o_tx_gap_busy;
    logic        crc_en = 1'b1, gap_bad = 1'b0;
    logic [15:0] min_len = 16'h40, max_len = 16'h618;
    logic [31:0] cnt [10];
    logic [31:0] q_rd [$];
    logic [2:0]  q_fr [$];
    integer      seed = 32'hae439b7d, err_total = 0, checks_done = 0;
    mpsgc_pkg::mpsgc_rx_status_s i_rx_status = '0;
    mpsgc_pkg::mpsgc_tx_class_s  i_tx_class = '0;
    always #2.5 i_ref_clk = ~i_ref_clk;
    mpsgc_port_stats DUT (.i_ref_clk, .i_reset, .i_reg_wr, .i_reg_rd, .i_reg_addr, .i_reg_wdata,
        .o_reg_rdata, .o_reg_rvalid, .i_phy_rx_dv, .i_phy_rxd, .i_mac_tx_en, .i_mac_txd, .o_rx_dv,
        .o_rxd, .o_mac_loopback_enable, .i_rx_frame_end, .i_rx_status, .o_rx_frame_accept,
        .o_rx_frame_drop, .o_rx_gap_error_flag, .o_rx_crc_check_enable, .i_tx_frame_end,
        .i_tx_class, .o_tx_gap_busy);
    mpsgc_phy_model phy (.i_ref_clk, .o_rx_dv(i_phy_rx_dv), .o_rxd(i_phy_rxd));
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        checks_done++;
        if (got !== exp) begin
            err_total++;
            $display("unexpected %s: expected %h seen %h", what, exp, got);
        end
    endtask : chk
    task automatic print_verdict;
        err_total += q_rd.size() + q_fr.size();
        $display("checks %0d mismatches %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : print_verdict
    // results are matched against the oldest note
    always @(negedge i_ref_clk) begin
        if (o_reg_rvalid === 1'b1)
            chk("rdata", q_rd.size() ? q_rd.pop_front() : 32'hx, o_reg_rdata);
        if ((o_rx_frame_accept | o_rx_frame_drop | o_rx_gap_error_flag) !== 1'b0)
            chk("frame", q_fr.size() ? q_fr.pop_front() : 3'bx,
                {o_rx_frame_accept, o_rx_frame_drop, o_rx_gap_error_flag});
    end
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(negedge i_ref_clk);
        i_reg_wr <= 1'b1;
        i_reg_addr <= a;
        i_reg_wdata <= d;
        @(negedge i_ref_clk);
        i_reg_wr <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        q_rd.push_back(e);
        @(negedge i_ref_clk);
        i_reg_rd <= 1'b1;
        i_reg_addr <= a;
        @(negedge i_ref_clk);
        i_reg_rd <= 1'b0;
    endtask : rd
    task automatic frame(input logic [15:0] len, input logic [4:0] f);
        logic bad;
        logic err;
        bad = len < min_len || len > max_len;
        err = gap_bad | f[3] | f[2] | bad | (f[4] & crc_en);
        cnt[0] += f[3];
        cnt[1] += bad;
        cnt[2] += f[2];
        cnt[7] += !err & f[1];
        cnt[8] += !err & !f[1] & f[0];
        cnt[9] += gap_bad;
        q_fr.push_back({!(err | f[1] | f[0]), err | f[1] | f[0], gap_bad});
        gap_bad = 1'b0;
        chk("crc_en", crc_en, o_rx_crc_check_enable);
        @(negedge i_ref_clk);
        i_rx_frame_end <= 1'b1;
        i_rx_status <= {len, f};
        @(negedge i_ref_clk);
        i_rx_frame_end <= 1'b0;
    endtask : frame
    task automatic tx(input logic [1:0] c);
        cnt[3]++;
        cnt[4] += c[1];
        cnt[5] += c == 2'b01;
        cnt[6] += c == 2'b00;
        @(negedge i_ref_clk);
        i_tx_frame_end <= 1'b1;
        i_tx_class <= c;
        @(negedge i_ref_clk);
        i_tx_frame_end <= 1'b0;
    endtask : tx
    task automatic gap(input logic [7:0] s, input logic [1:0] c1, input logic [1:0] c2);
        int n;
        int m;
        m = (s + 1) * 8;
        wr(8'hb0, {24'h0, s});
        tx(c1);
        tx(c2);
        n = 3;
        @(negedge i_ref_clk);
        while (o_tx_gap_busy === 1'b1 && n < 5000) begin
            n++;
            @(negedge i_ref_clk);
        end
        chk("gap_len", 1, n >= (m - 1) * 20 + 1 && n <= m * 20);
    endtask : gap
    initial begin
        logic [7:0]  ra [7] = '{8'hb0, 8'hb3, 8'hb4, 8'hb5, 8'hb6, 8'hb7, 8'haf};
        logic [31:0] rv [7] = '{32'hb, 32'h0, 32'h1, 32'ha, 32'h618, 32'h40, 32'h0};
        logic [31:0] rm [7] = '{32'hff, 32'h1, 32'h1, 32'h3f, 32'hffff, 32'hffff, 32'h0};
        int k;
        for (int i = 0; i < 10; i++) cnt[i] = 32'h0;
        repeat (20) @(negedge i_ref_clk);
        i_reset <= 1'b0;
        for (int i = 0; i < 10; i++) rd(8'ha5 + 8'(i), 32'h0);
        for (int i = 0; i < 7; i++) begin
            rd(ra[i], rv[i]);
            wr(ra[i], 32'hffffffff);
            rd(ra[i], rm[i]);
            wr(ra[i], rv[i]);
        end
        wr(8'ha5, 32'hffffffff);
        for (int i = 0; i < 48; i++) begin
            if (i == 24) begin
                wr(8'hb4, 32'h0);
                wr(8'hb6, 32'h30);
                wr(8'hb7, 32'h20);
                crc_en = 1'b0;
                max_len = 16'h30;
                min_len = 16'h20;
            end
            k = $unsigned($random(seed)) % 4;
            frame(k[1] ? max_len + k[0] : min_len - !k[0], 5'($random(seed)));
        end
        phy.send(40);
        frame(16'h28, 5'h0);
        repeat (300) @(negedge i_ref_clk);
        phy.send(40);
        gap_bad = 1'b1;
        frame(16'h28, 5'h0);
        wr(8'hb5, 32'h1);
        repeat (400) @(negedge i_ref_clk);
        phy.send(40);
        frame(16'h28, 5'h0);
        gap(8'h0b, 2'b10, 2'b01);
        gap(8'h00, 2'b11, 2'b00);
        for (int i = 0; i < 10; i++) rd(8'ha5 + 8'(i), cnt[i]);
        wr(8'hb3, 32'h1);
        chk("loop_en", 1, o_mac_loopback_enable);
        for (int i = 0; i < 16; i++) begin
            @(negedge i_ref_clk);
            chk("loop_rx", {i_mac_tx_en, i_mac_txd}, {o_rx_dv, o_rxd});
            i_mac_tx_en <= $random(seed);
            i_mac_txd <= $random(seed);
        end
        wr(8'hb3, 32'h0);
        for (int i = 0; i < 4; i++) begin
            @(negedge i_ref_clk);
            chk("norm_rx", {i_phy_rx_dv, i_phy_rxd}, {o_rx_dv, o_rxd});
        end
        print_verdict();
    end
    initial begin
        #200us;
        err_total++;
        print_verdict();
    end
endmodule : mpsgc_port_stats_test
bind mpsgc_port_stats mpsgc_asserts chk_i (.i_ref_clk, .i_reset, .i_reg_rd, .o_reg_rvalid,
    .i_phy_rx_dv, .i_mac_tx_en, .o_rx_dv, .o_mac_loopback_enable, .i_rx_frame_end, .i_rx_status,
    .o_rx_frame_accept, .o_rx_frame_drop, .o_rx_gap_error_flag, .i_tx_frame_end, .o_tx_gap_busy);
